/* inc/dma_ctrl_pkg.sv */
// Constants shared by the four-channel DMA control block.
package dma_ctrl_pkg;

    // --------------------------------------------------------------
    // Geometry
    // --------------------------------------------------------------
    localparam int NUM_CH = 4;
    localparam int ADDR_W = 8;

    // --------------------------------------------------------------
    // Register map: channel i sits at i * CH_STRIDE
    // --------------------------------------------------------------
    localparam logic [7:0] CH_STRIDE = 8'h20;
    localparam logic [4:0] OFF_MODE = 5'h00;
    localparam logic [4:0] OFF_COUNT = 5'h04;
    localparam logic [4:0] OFF_RELOAD = 5'h08;
    localparam logic [4:0] OFF_SRC = 5'h0c;
    localparam logic [4:0] OFF_DST = 5'h10;
    localparam logic [7:0] OFF_SWTRIG = 8'h80;
    localparam logic [7:0] OFF_ISTAT = 8'h84;
    localparam logic [7:0] OFF_IMASK = 8'h88;
    localparam logic [7:0] OFF_ACTIVE = 8'h8c;

    // --------------------------------------------------------------
    // Mode register fields
    // --------------------------------------------------------------
    localparam int MODE_SEL_LSB = 0;
    localparam int SRC_INC_BIT = 2;
    localparam int DST_INC_BIT = 3;
    localparam int SIZE_LSB = 4;
    localparam int TRIG_LSB = 6;
    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [1:0] MODE_SINGLE = 2'h1;
    localparam logic [1:0] MODE_REPEAT = 2'h3;
    localparam logic [1:0] SIZE_8 = 2'h0;
    localparam logic [1:0] SIZE_16 = 2'h1;
    localparam logic [1:0] SIZE_32 = 2'h2;

    // Trigger source codes index the peripheral request vector.
    localparam logic [2:0] TRIG_TIMER_A = 3'h0;
    localparam logic [2:0] TRIG_TIMER_B = 3'h1;
    localparam logic [2:0] TRIG_SERIAL_TX = 3'h2;
    localparam logic [2:0] TRIG_SERIAL_RX = 3'h3;
    localparam logic [2:0] TRIG_ADC = 3'h4;
    localparam logic [2:0] TRIG_IIO = 3'h5;
    localparam logic [2:0] TRIG_I2C = 3'h6;
    localparam logic [2:0] TRIG_SOFT_ONLY = 3'h7;

    // --------------------------------------------------------------
    // Values after reset and count thresholds
    // --------------------------------------------------------------
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [8:0] RST_MODE = 9'h000;
    localparam logic [31:0] COUNT_ONE = 32'h0000_0001;
    localparam logic [31:0] COUNT_ZERO = 32'h0000_0000;

    // Engine states, one-hot.
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_BUSY = 2'b10
    } eng_state_type;

endpackage : dma_ctrl_pkg

/* core/dma_ctrl.sv */
// Four-channel DMA control: channel registers, arbitration and transfer issue.
//
// Design decisions made here: the placing of the registers and strobed register access.
`timescale 1ns/10ps
// Function
// - Simultaneous requests resolved by fixed priority, channel 0 highest, channel 3 lowest.
// - Per-channel trigger selectable from timer, serial, ADC, IIO, I2C or software.
// - Each channel uses incrementing or fixed addressing, chosen by configuration.
// - Single mode finishes when count reaches zero and does not continue.
// - Repeat mode reloads count from reload register at zero and keeps going.
// - Single mode (01b) starts only if count was set above one beforehand.
// - Repeat mode (11b) starts only if count was set above one beforehand.
// - Writing 00b to mode bits disables the channel and halts its activity.
// - Repeat reload of count and addresses happens on the one-to-zero step.
// - Per-channel complete interrupt raised when count goes from one to zero.
// - Transfer unit size is 8, 16 or 32 bits by configuration.
module dma_ctrl (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata,
    input wire logic [7:0] periphReq,
    output logic xferValid,
    output logic [1:0] xferChan,
    output logic [31:0] xferSrc,
    output logic [31:0] xferDst,
    output logic [1:0] xferSize,
    input wire logic xferDone,
    output logic irq
);

    // --------------------------------------------------------------
    // Bus decode
    // --------------------------------------------------------------

    // Channel space is the lower half of the map; globals live above it.
    logic chSpace;
    logic [1:0] chSel;
    logic [4:0] regOff;

    assign chSpace = ~regAddr[7];
    assign chSel = regAddr[6:5];
    assign regOff = regAddr[4:0];

    // --------------------------------------------------------------
    // Channel state
    // --------------------------------------------------------------
    logic [8:0] mode_r [dma_ctrl_pkg::NUM_CH];
    logic [31:0] count_r [dma_ctrl_pkg::NUM_CH];
    logic [31:0] reload_r [dma_ctrl_pkg::NUM_CH];
    logic [31:0] src_r [dma_ctrl_pkg::NUM_CH];
    logic [31:0] dst_r [dma_ctrl_pkg::NUM_CH];
    logic [31:0] srcStart_r [dma_ctrl_pkg::NUM_CH];
    logic [31:0] dstStart_r [dma_ctrl_pkg::NUM_CH];

    // Flags hold one bit per channel.
    logic [3:0] pending_r;
    logic [3:0] active_r;
    logic [3:0] intStat_r;
    logic [3:0] intMask_r;

    logic [3:0] eligible;
    logic [3:0] trigHit;
    logic [3:0] doneHit;
    logic [3:0] enabled;
    logic [3:0] swTrig;

    // The engine serves one channel at a time.
    dma_ctrl_pkg::eng_state_type state_r;
    logic [1:0] curChan_r;

    // Software trigger is a write pulse; it is never stored.
    assign swTrig = (regWr && regAddr == dma_ctrl_pkg::OFF_SWTRIG) ? regWdata[3:0] : 4'h0;

    // Logic repeats once per channel.
    genvar gi;
    generate
        for (gi = 0; gi < dma_ctrl_pkg::NUM_CH; gi++) begin : g_ch
            logic wrCh;
            logic [1:0] modeSel;
            logic [1:0] unitSize;
            logic [2:0] trigSrc;
            logic [31:0] stepBytes;
            logic lastStep;

            // Views of the bus and of the mode fields.
            assign wrCh = regWr && chSpace && chSel == 2'(gi);
            assign modeSel = mode_r[gi][dma_ctrl_pkg::MODE_SEL_LSB +: 2];
            assign unitSize = mode_r[gi][dma_ctrl_pkg::SIZE_LSB +: 2];
            assign trigSrc = mode_r[gi][dma_ctrl_pkg::TRIG_LSB +: 3];
            assign lastStep = count_r[gi] == dma_ctrl_pkg::COUNT_ONE;

            // Only 01b and 11b run; the undefined 10b code is treated as off.
            assign enabled[gi] = modeSel == dma_ctrl_pkg::MODE_SINGLE
                || modeSel == dma_ctrl_pkg::MODE_REPEAT;

            // A fresh start needs a count above one; a running channel may finish on one.
            assign eligible[gi] = enabled[gi] && pending_r[gi]
                && (active_r[gi] || count_r[gi] > dma_ctrl_pkg::COUNT_ONE);

            // The selected peripheral line or the software strobe raises a request.
            assign trigHit[gi] = swTrig[gi]
                || (trigSrc != dma_ctrl_pkg::TRIG_SOFT_ONLY && periphReq[trigSrc]);

            assign doneHit[gi] = state_r == dma_ctrl_pkg::ST_BUSY && xferDone
                && curChan_r == 2'(gi) && enabled[gi];

            // Unit size in bytes; the reserved size code moves single bytes.
            always_comb begin
                unique case (unitSize)
                    dma_ctrl_pkg::SIZE_16: stepBytes = 32'h0000_0002;
                    dma_ctrl_pkg::SIZE_32: stepBytes = 32'h0000_0004;
                    default: stepBytes = 32'h0000_0001;
                endcase
            end

            // Mode register; software alone owns it.
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    mode_r[gi] <= dma_ctrl_pkg::RST_MODE;
                end else if (wrCh && regOff == dma_ctrl_pkg::OFF_MODE) begin
                    mode_r[gi] <= regWdata[8:0];
                end
            end

            // Reload value and the start addresses used for repeat restarts.
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    reload_r[gi] <= dma_ctrl_pkg::RST_WORD;
                    srcStart_r[gi] <= dma_ctrl_pkg::RST_WORD;
                    dstStart_r[gi] <= dma_ctrl_pkg::RST_WORD;
                end else begin
                    if (wrCh && regOff == dma_ctrl_pkg::OFF_RELOAD) begin
                        reload_r[gi] <= regWdata;
                    end
                    if (wrCh && regOff == dma_ctrl_pkg::OFF_SRC) begin
                        srcStart_r[gi] <= regWdata;
                    end
                    if (wrCh && regOff == dma_ctrl_pkg::OFF_DST) begin
                        dstStart_r[gi] <= regWdata;
                    end
                end
            end

            // Transfer count; a software write wins over the engine's step.
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    count_r[gi] <= dma_ctrl_pkg::RST_WORD;
                end else if (wrCh && regOff == dma_ctrl_pkg::OFF_COUNT) begin
                    count_r[gi] <= regWdata;
                end else if (doneHit[gi]) begin
                    if (lastStep && modeSel == dma_ctrl_pkg::MODE_REPEAT) begin
                        count_r[gi] <= reload_r[gi];
                    end else begin
                        count_r[gi] <= count_r[gi] - dma_ctrl_pkg::COUNT_ONE;
                    end
                end
            end

            // Working addresses: step, hold, or restart at the repeat reload.
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    src_r[gi] <= dma_ctrl_pkg::RST_WORD;
                    dst_r[gi] <= dma_ctrl_pkg::RST_WORD;
                end else if (wrCh && regOff == dma_ctrl_pkg::OFF_SRC) begin
                    src_r[gi] <= regWdata;
                end else if (wrCh && regOff == dma_ctrl_pkg::OFF_DST) begin
                    dst_r[gi] <= regWdata;
                end else if (doneHit[gi]) begin
                    if (lastStep && modeSel == dma_ctrl_pkg::MODE_REPEAT) begin
                        src_r[gi] <= srcStart_r[gi];
                        dst_r[gi] <= dstStart_r[gi];
                    end else begin
                        if (mode_r[gi][dma_ctrl_pkg::SRC_INC_BIT]) begin
                            src_r[gi] <= src_r[gi] + stepBytes;
                        end
                        if (mode_r[gi][dma_ctrl_pkg::DST_INC_BIT]) begin
                            dst_r[gi] <= dst_r[gi] + stepBytes;
                        end
                    end
                end
            end

            // Request latch; a new trigger in the serving cycle is kept.
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    pending_r[gi] <= 1'b0;
                end else if (!enabled[gi]) begin
                    pending_r[gi] <= 1'b0;
                end else if (trigHit[gi]) begin
                    pending_r[gi] <= 1'b1;
                end else if (doneHit[gi]) begin
                    pending_r[gi] <= 1'b0;
                end
            end

            // Running flag: set by the first move, dropped at the single-mode end.
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    active_r[gi] <= 1'b0;
                end else if (!enabled[gi]) begin
                    active_r[gi] <= 1'b0;
                end else if (doneHit[gi]) begin
                    active_r[gi] <= !(lastStep && modeSel == dma_ctrl_pkg::MODE_SINGLE);
                end
            end

            // Completion flag; a new event beats a write-one-to-clear.
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    intStat_r[gi] <= 1'b0;
                end else if (doneHit[gi] && lastStep) begin
                    intStat_r[gi] <= 1'b1;
                end else if (regWr && regAddr == dma_ctrl_pkg::OFF_ISTAT && regWdata[gi]) begin
                    intStat_r[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // --------------------------------------------------------------
    // Arbitration and transfer issue
    // --------------------------------------------------------------

    // Lowest-numbered eligible channel wins.
    // The scan runs down, so the lowest hit stands.
    logic [1:0] winner;

    always_comb begin
        winner = 2'd3;
        for (int k = dma_ctrl_pkg::NUM_CH - 1; k >= 0; k--) begin
            if (eligible[k]) begin
                winner = 2'(k);
            end
        end
    end

    // One transfer at a time; disabling the served channel abandons it.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= dma_ctrl_pkg::ST_IDLE;
            curChan_r <= 2'd0;
        end else begin
            unique case (state_r)
                dma_ctrl_pkg::ST_IDLE: begin
                    if (|eligible) begin
                        state_r <= dma_ctrl_pkg::ST_BUSY;
                        curChan_r <= winner;
                    end
                end
                dma_ctrl_pkg::ST_BUSY: begin
                    if (xferDone || !enabled[curChan_r]) begin
                        state_r <= dma_ctrl_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Issue strobe and its descriptor, held steady until the next issue.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            xferValid <= 1'b0;
            xferChan <= 2'd0;
            xferSrc <= dma_ctrl_pkg::RST_WORD;
            xferDst <= dma_ctrl_pkg::RST_WORD;
            xferSize <= dma_ctrl_pkg::SIZE_8;
        end else begin
            xferValid <= state_r == dma_ctrl_pkg::ST_IDLE && |eligible;
            if (state_r == dma_ctrl_pkg::ST_IDLE && |eligible) begin
                xferChan <= winner;
                xferSrc <= src_r[winner];
                xferDst <= dst_r[winner];
                xferSize <= mode_r[winner][dma_ctrl_pkg::SIZE_LSB +: 2];
            end
        end
    end

    // --------------------------------------------------------------
    // Interrupt mask and output
    // --------------------------------------------------------------

    // The mask gates only the line.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            intMask_r <= 4'h0;
        end else if (regWr && regAddr == dma_ctrl_pkg::OFF_IMASK) begin
            intMask_r <= regWdata[3:0];
        end
    end

    // Registered, so the line lags the status bit by one cycle.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(intStat_r & intMask_r);
        end
    end

    // --------------------------------------------------------------
    // Read path
    // --------------------------------------------------------------

    // Unmapped addresses read as zero.
    logic [31:0] rdNxt;

    always_comb begin
        rdNxt = 32'h0000_0000;
        if (chSpace) begin
            unique case (regOff)
                dma_ctrl_pkg::OFF_MODE: rdNxt = {23'h0, mode_r[chSel]};
                dma_ctrl_pkg::OFF_COUNT: rdNxt = count_r[chSel];
                dma_ctrl_pkg::OFF_RELOAD: rdNxt = reload_r[chSel];
                dma_ctrl_pkg::OFF_SRC: rdNxt = src_r[chSel];
                dma_ctrl_pkg::OFF_DST: rdNxt = dst_r[chSel];
                default: rdNxt = 32'h0000_0000;
            endcase
        end else begin
            // Globals decode on the full address.
            unique case (regAddr)
                dma_ctrl_pkg::OFF_ISTAT: rdNxt = {28'h0, intStat_r};
                dma_ctrl_pkg::OFF_IMASK: rdNxt = {28'h0, intMask_r};
                dma_ctrl_pkg::OFF_ACTIVE: rdNxt = {24'h0, pending_r, active_r};
                default: rdNxt = 32'h0000_0000;
            endcase
        end
    end

    // Data stands only in the cycle after the strobe.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            regRdata <= dma_ctrl_pkg::RST_WORD;
        end else begin
            regRdata <= regRd ? rdNxt : dma_ctrl_pkg::RST_WORD;
        end
    end

endmodule : dma_ctrl

/* sim/dma_ctrl_props.sv */
// Port-level concurrent checks for the DMA control block.
`timescale 1ns/10ps
module dma_ctrl_props (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [31:0] regRdata,
    input wire logic [7:0] periphReq,
    input wire logic xferValid,
    input wire logic [1:0] xferChan,
    input wire logic [31:0] xferSrc,
    input wire logic [31:0] xferDst,
    input wire logic [1:0] xferSize,
    input wire logic xferDone,
    input wire logic irq
);
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    // One clock domain, so clocking and reset are given once here.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    a_issue_one_pulse: assert property (xferValid |=> !xferValid)
        else $error("transfer issue pulse lasted more than one cycle");
    a_one_outstanding: assert property (
        xferValid |=> (!xferValid until_with (xferDone || regWr)))
        else $error("new transfer issued before the previous one completed");
    a_done_no_issue: assert property (xferDone |-> !xferValid)
        else $error("transfer issued in the completion cycle");
    a_descr_held: assert property (
        !xferValid |-> $stable({xferChan, xferSrc, xferDst, xferSize}))
        else $error("transfer descriptor changed without an issue");
    a_size_legal: assert property (xferValid |-> xferSize != 2'h3)
        else $error("reserved unit size issued");
    a_irq_rise_cause: assert property (
        $rose(irq) |-> ($past(xferDone, 2) || $past(regWr, 2)))
        else $error("interrupt rose without a completion or register write");
    a_irq_fall_cause: assert property ($fell(irq) |-> $past(regWr, 2))
        else $error("interrupt fell without a register write");
    a_rdata_idle_zero: assert property (!regRd |=> regRdata == 32'h0000_0000)
        else $error("read data not zero outside the read answer cycle");
endmodule : dma_ctrl_props

bind dma_ctrl dma_ctrl_props u_props (.clk(clk), .nrst(nrst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .periphReq(periphReq), .xferValid(xferValid), .xferChan(xferChan), .xferSrc(xferSrc),
    .xferDst(xferDst), .xferSize(xferSize), .xferDone(xferDone), .irq(irq));

/* sim/dma_bus_model.sv */
// Memory bus stand-in that completes each issued transfer.
`timescale 1ns/10ps
module dma_bus_model (
    input wire logic clk,
    input wire logic nrst,
    input wire logic xferValid,
    input wire logic [1:0] lat,
    output logic xferDone
);
    // ----------------------------------------
    // Completion timer
    // ----------------------------------------
    logic [1:0] waitCnt_r;

    // Latency zero answers at once; larger values stall the engine.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            waitCnt_r <= 2'h0;
            xferDone <= 1'h0;
        end else begin
            xferDone <= 1'h0;
            if (xferValid) begin
                waitCnt_r <= lat;
                xferDone <= (lat == 2'h0);
            end else if (waitCnt_r != 2'h0) begin
                waitCnt_r <= waitCnt_r - 2'h1;
                xferDone <= (waitCnt_r == 2'h1);
            end
        end
    end
endmodule : dma_bus_model

/* sim/dma_ctrl_bench.sv */
// Self-checking testbench for the DMA control block.
`timescale 1ns/10ps
module dma_ctrl_bench;
    // ----------------------------------------
    // Stimulus, checks and verdict
    // ----------------------------------------
    typedef struct packed {
        logic [1:0] ch;
        logic [2:0] trig;
        logic [1:0] size;
        logic sInc;
        logic dInc;
        logic [31:0] sStep;
        logic [31:0] dStep;
    } row_type;

    // Each row: channel, source, size and step flags, then expected address steps.
    row_type rows [8] = '{
        '{2'h0, 3'h0, 2'h0, 1'h1, 1'h1, 32'h1, 32'h1},
        '{2'h1, 3'h1, 2'h1, 1'h1, 1'h0, 32'h2, 32'h0},
        '{2'h2, 3'h2, 2'h2, 1'h0, 1'h1, 32'h0, 32'h4},
        '{2'h3, 3'h3, 2'h0, 1'h0, 1'h0, 32'h0, 32'h0},
        '{2'h0, 3'h4, 2'h1, 1'h1, 1'h1, 32'h2, 32'h2},
        '{2'h1, 3'h5, 2'h2, 1'h1, 1'h1, 32'h4, 32'h4},
        '{2'h2, 3'h6, 2'h0, 1'h1, 1'h0, 32'h1, 32'h0},
        '{2'h3, 3'h7, 2'h2, 1'h0, 1'h1, 32'h0, 32'h4}
    };
    logic clk = 1'h0;
    logic nrst = 1'h0;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWdata = 32'h0000_0000;
    logic regWr = 1'h0;
    logic regRd = 1'h0;
    logic [7:0] periphReq = 8'h00;
    logic [1:0] lat = 2'h0;
    logic [31:0] regRdata, xferSrc, xferDst, rdv, k;
    logic [1:0] xferChan, xferSize, md;
    logic xferValid, xferDone, irq;
    row_type r;
    int failures = 0;
    int num_checks = 0;

    dma_ctrl uut (.clk(clk), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .periphReq(periphReq),
        .xferValid(xferValid), .xferChan(xferChan), .xferSrc(xferSrc), .xferDst(xferDst),
        .xferSize(xferSize), .xferDone(xferDone), .irq(irq));
    dma_bus_model mem (.clk(clk), .nrst(nrst), .xferValid(xferValid), .lat(lat),
        .xferDone(xferDone));

    // Free-running system clock, 25 ns period.
    initial begin
        forever #12.5 clk = ~clk;
    end

    function automatic logic [7:0] ra(input logic [1:0] c, input logic [4:0] o);
        return {1'h0, c, o};
    endfunction : ra
    function automatic logic [31:0] mw(input logic [1:0] m, input logic [2:0] t,
        input logic [1:0] z, input logic s, input logic d);
        return {23'h00_0000, t, z, d, s, m};
    endfunction : mw
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // Every bus task ends 1 ns past an edge so outputs have settled.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'h1;
        @(posedge clk);
        regWr <= 1'h0;
        #1;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'h1;
        @(posedge clk);
        regRd <= 1'h0;
        #1 rdv = regRdata;
    endtask : rd
    task automatic fire(input logic [1:0] c, input logic [2:0] t);
        if (t == dma_ctrl_pkg::TRIG_SOFT_ONLY) begin
            wr(dma_ctrl_pkg::OFF_SWTRIG, 32'h1 << c);
        end else begin
            @(posedge clk);
            periphReq[t] <= 1'h1;
            @(posedge clk);
            periphReq[t] <= 1'h0;
            #1;
        end
    endtask : fire
    // Waits for one issue, compares it, then waits for its completion.
    task automatic take(input logic [1:0] c, input logic [31:0] s, input logic [31:0] d,
        input logic [1:0] z);
        int n;
        n = 0;
        while (xferValid !== 1'h1 && n < 30) begin
            @(posedge clk);
            #1 n++;
        end
        chk("issue", 32'h1, {31'h0, xferValid});
        chk("xferChan", {30'h0, c}, {30'h0, xferChan});
        chk("xferSrc", s, xferSrc);
        chk("xferDst", d, xferDst);
        chk("xferSize", {30'h0, z}, {30'h0, xferSize});
        n = 0;
        while (xferDone !== 1'h1 && n < 30) begin
            @(posedge clk);
            #1 n++;
        end
        chk("done", 32'h1, {31'h0, xferDone});
        @(posedge clk);
        #1;
    endtask : take
    task automatic quiet;
        repeat (8) begin
            @(posedge clk);
            #1 chk("no issue", 32'h0, {31'h0, xferValid});
        end
    endtask : quiet
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : tally_and_finish

    // Watchdog: the whole run needs well under 5000 cycles.
    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        tally_and_finish();
    end

    // Main sequence: reset, table rows, then the hand-written cases.
    initial begin
        repeat (3) @(posedge clk);
        nrst <= 1'h1;
        rd(ra(2'h3, dma_ctrl_pkg::OFF_COUNT));
        chk("count after reset", 32'h0, rdv);
        wr(8'hfc, 32'hffff_ffff);
        rd(8'hfc);
        chk("unmapped read", 32'h0, rdv);
        $display("reset test done");
        for (int i = 0; i < 8; i++) begin
            r = rows[i];
            lat <= 2'(i);
            wr(ra(r.ch, dma_ctrl_pkg::OFF_COUNT), 32'h2);
            wr(ra(r.ch, dma_ctrl_pkg::OFF_SRC), 32'h0000_1000);
            wr(ra(r.ch, dma_ctrl_pkg::OFF_DST), 32'h0000_2000);
            wr(ra(r.ch, 5'h00), mw(dma_ctrl_pkg::MODE_SINGLE, r.trig, r.size, r.sInc, r.dInc));
            for (k = 32'h0; k < 32'h2; k++) begin
                fire(r.ch, r.trig);
                take(r.ch, 32'h0000_1000 + k * r.sStep, 32'h0000_2000 + k * r.dStep, r.size);
            end
            rd(ra(r.ch, dma_ctrl_pkg::OFF_COUNT));
            chk("count at end", 32'h0, rdv);
            rd(dma_ctrl_pkg::OFF_ISTAT);
            chk("status", 32'h1 << r.ch, rdv);
            fire(r.ch, r.trig);
            quiet();
            wr(dma_ctrl_pkg::OFF_ISTAT, 32'h1 << r.ch);
            wr(ra(r.ch, 5'h00), 32'h0);
            $display("row %0d done", i);
        end
        // All four channels triggered at one edge must be served in channel order.
        for (int c = 0; c < 4; c++) begin
            wr(ra(2'(c), dma_ctrl_pkg::OFF_COUNT), 32'h2);
            wr(ra(2'(c), dma_ctrl_pkg::OFF_SRC), 32'h0000_3000);
            wr(ra(2'(c), dma_ctrl_pkg::OFF_DST), 32'h0000_3100);
            wr(ra(2'(c), 5'h00), mw(2'h1, 3'h7, 2'h0, 1'h0, 1'h0));
        end
        wr(dma_ctrl_pkg::OFF_SWTRIG, 32'h0000_000f);
        for (int c = 0; c < 4; c++) take(2'(c), 32'h0000_3000, 32'h0000_3100, 2'h0);
        for (int c = 0; c < 4; c++) wr(ra(2'(c), 5'h00), 32'h0);
        $display("priority test done");
        // Repeat mode: the one-to-zero step reloads count and source address.
        lat <= 2'h0;
        wr(ra(2'h1, dma_ctrl_pkg::OFF_COUNT), 32'h2);
        wr(ra(2'h1, dma_ctrl_pkg::OFF_RELOAD), 32'h3);
        wr(ra(2'h1, dma_ctrl_pkg::OFF_SRC), 32'h0000_4000);
        wr(ra(2'h1, dma_ctrl_pkg::OFF_DST), 32'h0000_5000);
        wr(ra(2'h1, 5'h00), mw(dma_ctrl_pkg::MODE_REPEAT, 3'h7, 2'h0, 1'h1, 1'h0));
        for (k = 32'h0; k < 32'h3; k++) begin
            fire(2'h1, 3'h7);
            take(2'h1, 32'h0000_4000 + (k % 32'h2), 32'h0000_5000, 2'h0);
        end
        rd(ra(2'h1, dma_ctrl_pkg::OFF_COUNT));
        chk("count after reload", 32'h2, rdv);
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(dma_ctrl_pkg::OFF_IMASK, 32'h2);
        @(posedge clk);
        #1 chk("irq raised", 32'h1, {31'h0, irq});
        wr(dma_ctrl_pkg::OFF_ISTAT, 32'h2);
        @(posedge clk);
        #1 chk("irq cleared", 32'h0, {31'h0, irq});
        wr(ra(2'h1, 5'h00), 32'h0);
        $display("repeat test done");
        // A count of one must not start a channel; mode 00b stops it.
        for (int j = 0; j < 2; j++) begin
            md = j ? dma_ctrl_pkg::MODE_REPEAT : dma_ctrl_pkg::MODE_SINGLE;
            wr(ra(2'h2, dma_ctrl_pkg::OFF_COUNT), 32'h1);
            wr(ra(2'h2, dma_ctrl_pkg::OFF_SRC), 32'h0000_6000);
            wr(ra(2'h2, dma_ctrl_pkg::OFF_DST), 32'h0000_7000);
            wr(ra(2'h2, 5'h00), mw(md, 3'h7, 2'h2, 1'h0, 1'h0));
            fire(2'h2, 3'h7);
            quiet();
            wr(ra(2'h2, dma_ctrl_pkg::OFF_COUNT), 32'h2);
            take(2'h2, 32'h0000_6000, 32'h0000_7000, 2'h2);
            wr(ra(2'h2, 5'h00), 32'h0);
            fire(2'h2, 3'h7);
            quiet();
            rd(dma_ctrl_pkg::OFF_ACTIVE);
            chk("active", 32'h0, rdv);
        end
        $display("guard test done");
        tally_and_finish();
    end
endmodule : dma_ctrl_bench
